// file: logic/aps_seq.sv
// power-up sequencer and host-supply supervision of the alarm front end
// assumes synchronous inputs on clk_i and a classic wishbone master
//
// Function
// R1: wait 6 ms after core supply rises
// R2: then enable boost at 3.8 V
// R3: hold until boost power-good asserts
// R4: sense strap 2 ms, load host/boost settings
// R5: strap decodes four host/boost pairs
// R6: boost good again, then enable host regulator
// R7: active only after host power-good
// R8: same sequence whether boost used or not
// R9: host setting selects 1.5/1.8/2.5/3.3 V
// R10: software may rewrite host setting later
// R11: disable bit turns host regulator off
// R12: host power-good deglitched over 125 us
// R13: error if not good 10 ms after change
// R14: error and mask clear enter fault state
// R15: internal regulator always enabled
// R16: photo reference 50 mV under select and enable
// R17: core supply drop restarts whole sequence
//
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "aps_defs.svh"

module aps_seq #(
  parameter int unsigned INIT_CYC = `APS_INIT_CYC,
  parameter int unsigned STRAP_CYC = `APS_STRAP_CYC,
  parameter int unsigned HOST_TIMEOUT_CYC = `APS_HOST_TIMEOUT_CYC,
  parameter int unsigned DEGLITCH_CYC = `APS_DEGLITCH_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic core_supply_up_i,
  input wire logic boost_good_i,
  input wire logic host_supply_good_i,
  input wire logic [1:0] supply_select_strap_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic boost_enable_o,
  output aps_pkg::aps_bst_lvl_t boost_output_setting_o,
  output logic host_regulator_enable_o,
  output aps_pkg::aps_host_lvl_t host_supply_voltage_setting_o,
  output logic internal_regulator_enable_o,
  output logic photo_reference_low_o,
  output logic active_o,
  output logic fault_o
);
  import aps_pkg::*;

  localparam logic [19:0] INIT_LAST = 20'(INIT_CYC - 1);
  localparam logic [19:0] STRAP_LAST = 20'(STRAP_CYC - 1);
  localparam logic [19:0] HOST_LAST = 20'(HOST_TIMEOUT_CYC - 1);

  // ----------------------------------------
  // deglitch of host power-good
  // ----------------------------------------
  aps_pg_if pg_if ();
  assign pg_if.raw = host_supply_good_i;

  aps_deglitch #(
    .DEGLITCH_CYC(DEGLITCH_CYC)
  ) u_deglitch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pg(pg_if.filt)
  );

  logic host_good;
  assign host_good = pg_if.good;

  // ----------------------------------------
  // state
  // ----------------------------------------
  aps_state_t st_q, st_d;
  logic [19:0] cnt_q, cnt_d;
  logic [1:0] strap_q, strap_d;
  aps_host_lvl_t vset_q, vset_d;
  aps_bst_lvl_t bst_q, bst_d;
  logic host_dis_q, host_dis_d;
  logic mask_q, mask_d;
  logic ref_sel_q, ref_sel_d;
  logic amp_en_q, amp_en_d;
  logic gain_en_q, gain_en_d;
  logic err_q, err_d;
  logic [19:0] tmr_q, tmr_d;
  logic tmr_run_q, tmr_run_d;
  logic host_en_q, host_en_d;
  logic bst_en_q, bst_en_d;
  logic ref_low_q, ref_low_d;
  logic int_en_q;
  logic [31:0] rdat_q, rdat_d;
  logic ack_q, ack_d;

  logic req, wr_ctrl, wr_stat, host_on_d, restart;
  logic [31:0] ctrl_word, stat_word;

  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_ctrl = req && wb_we_i && wb_sel_i[0] && wb_adr_i == `APS_ADDR_CTRL;
  assign wr_stat = req && wb_we_i && wb_sel_i[0] && wb_adr_i == `APS_ADDR_STATUS;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 20'h00001;
    strap_d = strap_q;
    vset_d = vset_q;
    bst_d = bst_q;
    if (wr_ctrl) begin
      vset_d = aps_host_lvl_t'(wb_dat_i[`APS_CTRL_VSET_LSB +: 2]); // R10 R9
    end
    case (st_q)
      APS_ST_OFF: begin
        cnt_d = 20'h00000;
        if (core_supply_up_i) begin
          st_d = APS_ST_INIT;
        end
      end
      APS_ST_INIT: begin
        if (cnt_q == INIT_LAST) begin
          st_d = APS_ST_BOOST; // R1
          bst_d = APS_BST_3V8; // R2
        end
      end
      APS_ST_BOOST: begin
        cnt_d = 20'h00000;
        strap_d = supply_select_strap_i;
        // boost good gates the step even when the converter is not fitted
        if (boost_good_i) begin
          st_d = APS_ST_STRAP; // R3 R8
        end
      end
      APS_ST_STRAP: begin
        strap_d = supply_select_strap_i;
        if (supply_select_strap_i != strap_q) begin
          cnt_d = 20'h00000; // sensed level must stay steady for the whole window
        end else if (cnt_q == STRAP_LAST) begin
          st_d = APS_ST_RESETTLE; // R4
          case (strap_q) // R5
            `APS_STRAP_RES_GND: begin
              vset_d = APS_HOST_1V5;
              bst_d = APS_BST_2V7;
            end
            `APS_STRAP_SHORT_GND: begin
              vset_d = APS_HOST_1V8;
              bst_d = APS_BST_2V7;
            end
            `APS_STRAP_SHORT_RAIL: begin
              vset_d = APS_HOST_2V5;
              bst_d = APS_BST_3V8;
            end
            default: begin
              vset_d = APS_HOST_3V3;
              bst_d = APS_BST_4V7;
            end
          endcase
        end
      end
      APS_ST_RESETTLE: begin
        // cnt_q arrives nonzero, so the converter must drop power-good in the first cycle at the new target
        if (boost_good_i && cnt_q != 20'h00000) begin
          st_d = APS_ST_HOST; // R6 R8
        end
      end
      APS_ST_HOST: begin
        if (err_q && !mask_q) begin
          st_d = APS_ST_FAULT; // R14
        end else if (host_good) begin
          st_d = APS_ST_ACTIVE; // R7
        end
      end
      APS_ST_ACTIVE: begin
        if (err_q && !mask_q) begin
          st_d = APS_ST_FAULT; // R14
        end
      end
      APS_ST_FAULT: begin
        // leaves once software clears the flag or masks it
        if (!err_q || mask_q) begin
          st_d = APS_ST_HOST;
        end
      end
      default: begin
        st_d = APS_ST_OFF;
      end
    endcase
    if (!core_supply_up_i) begin
      st_d = APS_ST_OFF; // R17
      cnt_d = 20'h00000;
      bst_d = APS_BST_3V8;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= APS_ST_OFF;
      cnt_q <= 20'h00000;
      strap_q <= 2'h0;
      vset_q <= APS_HOST_1V5;
      bst_q <= APS_BST_3V8;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      strap_q <= strap_d;
      vset_q <= vset_d;
      bst_q <= bst_d;
    end
  end

  // ----------------------------------------
  // host supervision and controls
  // ----------------------------------------
  assign host_on_d = (st_d == APS_ST_HOST || st_d == APS_ST_ACTIVE) && !host_dis_d; // R11
  assign restart = (host_on_d && !host_en_q) || (host_on_d && vset_d != vset_q);

  always_comb begin
    host_dis_d = host_dis_q;
    mask_d = mask_q;
    ref_sel_d = ref_sel_q;
    amp_en_d = amp_en_q;
    gain_en_d = gain_en_q;
    if (wr_ctrl) begin
      host_dis_d = wb_dat_i[`APS_CTRL_HOST_DIS];
      mask_d = wb_dat_i[`APS_CTRL_ERR_MASK];
      ref_sel_d = wb_dat_i[`APS_CTRL_REF_SEL];
      amp_en_d = wb_dat_i[`APS_CTRL_AMP_EN];
      gain_en_d = wb_dat_i[`APS_CTRL_GAIN_EN];
    end
    tmr_d = tmr_q;
    tmr_run_d = tmr_run_q;
    err_d = err_q;
    if (wr_stat && wb_dat_i[`APS_STAT_ERR]) begin
      err_d = 1'b0;
    end
    if (!host_on_d) begin
      tmr_run_d = 1'b0;
    end else if (restart) begin
      tmr_d = 20'h00000; // R13
      tmr_run_d = 1'b1;
    end else if (tmr_run_q) begin
      tmr_d = tmr_q + 20'h00001;
      if (tmr_q == HOST_LAST) begin
        tmr_run_d = 1'b0;
        // the set is placed after the clear so a same-cycle event wins
        if (!host_good) begin
          err_d = 1'b1; // R13
        end
      end
    end
    if (!core_supply_up_i) begin
      err_d = 1'b0; // R17
    end
    host_en_d = host_on_d;
    bst_en_d = st_d != APS_ST_OFF && st_d != APS_ST_INIT; // R2
    ref_low_d = ref_sel_d && (amp_en_d || gain_en_d); // R16
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_dis_q <= 1'b0;
      mask_q <= 1'b0;
      ref_sel_q <= 1'b0;
      amp_en_q <= 1'b0;
      gain_en_q <= 1'b0;
      tmr_q <= 20'h00000;
      tmr_run_q <= 1'b0;
      err_q <= 1'b0;
      host_en_q <= 1'b0;
      bst_en_q <= 1'b0;
      ref_low_q <= 1'b0;
      int_en_q <= 1'b1; // R15
    end else begin
      host_dis_q <= host_dis_d;
      mask_q <= mask_d;
      ref_sel_q <= ref_sel_d;
      amp_en_q <= amp_en_d;
      gain_en_q <= gain_en_d;
      tmr_q <= tmr_d;
      tmr_run_q <= tmr_run_d;
      err_q <= err_d;
      host_en_q <= host_en_d;
      bst_en_q <= bst_en_d;
      ref_low_q <= ref_low_d;
      int_en_q <= 1'b1; // R15
    end
  end

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  assign ctrl_word = {25'h0000000, gain_en_q, amp_en_q, ref_sel_q, mask_q, host_dis_q, vset_q};
  assign stat_word = {22'h000000, strap_q, 1'b0, st_q, (st_q == APS_ST_FAULT), (st_q == APS_ST_ACTIVE),
    host_good, err_q};

  // one wait state: ack in the cycle after the request is seen, unmapped reads give zero
  always_comb begin
    ack_d = req;
    rdat_d = 32'h00000000;
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        `APS_ADDR_CTRL: rdat_d = ctrl_word;
        `APS_ADDR_STATUS: rdat_d = stat_word;
        default: rdat_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign boost_enable_o = bst_en_q;
  assign boost_output_setting_o = bst_q;
  assign host_regulator_enable_o = host_en_q;
  assign host_supply_voltage_setting_o = vset_q;
  assign internal_regulator_enable_o = int_en_q;
  assign photo_reference_low_o = ref_low_q;
  assign active_o = st_q == APS_ST_ACTIVE;
  assign fault_o = st_q == APS_ST_FAULT;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_INIT_SPAN: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    (st_q == APS_ST_BOOST && $past(st_q) == APS_ST_INIT) |-> $past(cnt_q) == INIT_LAST)
    else $error("boost step began before the initialisation interval ended");
  AST_BOOST_TARGET: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    st_q == APS_ST_BOOST |-> (bst_en_q && bst_q == APS_BST_3V8))
    else $error("boost not enabled at its first target");
  AST_BOOST_WAIT: assert property (@(posedge clk_i) disable iff (rst_i) // R3
    (st_q == APS_ST_BOOST && !boost_good_i && core_supply_up_i) |=> st_q == APS_ST_BOOST)
    else $error("sequence advanced without boost power-good");
  AST_STRAP_SPAN: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    (st_q == APS_ST_RESETTLE && $past(st_q) == APS_ST_STRAP) |-> $past(cnt_q) == STRAP_LAST)
    else $error("strap sensed for the wrong time");
  AST_STRAP_DECODE: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    (st_q == APS_ST_RESETTLE && $past(st_q) == APS_ST_STRAP && strap_q == `APS_STRAP_CAP_GND)
    |-> (vset_q == APS_HOST_3V3 && bst_q == APS_BST_4V7))
    else $error("capacitor strap decoded wrongly");
  AST_HOST_ENABLE: assert property (@(posedge clk_i) disable iff (rst_i) // R6 R11
    (st_q == APS_ST_HOST || st_q == APS_ST_ACTIVE) |-> host_en_q == !host_dis_q)
    else $error("host regulator enable disagrees with state and disable bit");
  AST_ACTIVE_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    (st_q == APS_ST_ACTIVE && $past(st_q) == APS_ST_HOST) |-> $past(host_good))
    else $error("active state entered without host power-good");
  AST_ERR_TIMEOUT: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    $rose(err_q) |-> ($past(tmr_q) == HOST_LAST && !$past(host_good)))
    else $error("host error flag set at the wrong moment");
  AST_FAULT_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    (st_q == APS_ST_ACTIVE && err_q && !mask_q && core_supply_up_i) |=> st_q == APS_ST_FAULT)
    else $error("fault state not entered on unmasked error");
  AST_INT_REG_ON: assert property (@(posedge clk_i) disable iff (rst_i) // R15
    internal_regulator_enable_o)
    else $error("internal regulator switched off");
  AST_SUPPLY_DROP: assert property (@(posedge clk_i) disable iff (rst_i) // R17
    !core_supply_up_i |=> (st_q == APS_ST_OFF && !host_en_q && !err_q))
    else $error("sequence not restarted after core supply drop");
  AST_WB_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle after request");

endmodule

// file: logic/aps_defs.svh
// constants of the alarm front-end power sequencer: offsets, fields, resets, times
// assumes a 50 MHz system clock; included by the package and the design modules
`ifndef APS_DEFS_SVH
`define APS_DEFS_SVH

// ----------------------------------------
// clock and times
// ----------------------------------------
`define APS_CLK_MHZ 50
`define APS_INIT_TIME_US 6000
`define APS_STRAP_TIME_US 2000
`define APS_HOST_TIMEOUT_US 10000
`define APS_DEGLITCH_TIME_NS 125000
`define APS_INIT_CYC (`APS_INIT_TIME_US * `APS_CLK_MHZ)
`define APS_STRAP_CYC (`APS_STRAP_TIME_US * `APS_CLK_MHZ)
`define APS_HOST_TIMEOUT_CYC (`APS_HOST_TIMEOUT_US * `APS_CLK_MHZ)
`define APS_DEGLITCH_CYC ((`APS_DEGLITCH_TIME_NS * `APS_CLK_MHZ) / 1000)

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define APS_ADDR_CTRL 8'h00
`define APS_ADDR_STATUS 8'h04

// ctrl fields
`define APS_CTRL_VSET_LSB 0
`define APS_CTRL_HOST_DIS 2
`define APS_CTRL_ERR_MASK 3
`define APS_CTRL_REF_SEL 4
`define APS_CTRL_AMP_EN 5
`define APS_CTRL_GAIN_EN 6
`define APS_CTRL_RESET 7'h00

// status fields
`define APS_STAT_ERR 0
`define APS_STAT_GOOD 1
`define APS_STAT_ACTIVE 2
`define APS_STAT_FAULT 3
`define APS_STAT_STATE_LSB 4
`define APS_STAT_STRAP_LSB 8

// ----------------------------------------
// strap sense codes
// ----------------------------------------
`define APS_STRAP_RES_GND 2'h0
`define APS_STRAP_SHORT_GND 2'h1
`define APS_STRAP_SHORT_RAIL 2'h2
`define APS_STRAP_CAP_GND 2'h3

`endif

// file: logic/aps_pkg.sv
// types of the alarm front-end power sequencer
// assumes aps_defs.svh for all numeric constants
`include "aps_defs.svh"

package aps_pkg;

  // host regulator levels
  typedef enum logic [1:0] {
    APS_HOST_1V5,
    APS_HOST_1V8,
    APS_HOST_2V5,
    APS_HOST_3V3
  } aps_host_lvl_t;

  // boost converter targets
  typedef enum logic [1:0] {
    APS_BST_2V7,
    APS_BST_3V8,
    APS_BST_4V7
  } aps_bst_lvl_t;

  typedef enum logic [2:0] {
    APS_ST_OFF,
    APS_ST_INIT,
    APS_ST_BOOST,
    APS_ST_STRAP,
    APS_ST_RESETTLE,
    APS_ST_HOST,
    APS_ST_ACTIVE,
    APS_ST_FAULT
  } aps_state_t;

endpackage

// file: logic/aps_pg_if.sv
// carrier between the sequencer and its power-good deglitch filter
// assumes both ends run on the one system clock
`timescale 1ns/100ps

interface aps_pg_if;
  logic raw;
  logic good;
  modport filt (input raw, output good);
  modport user (output raw, input good);
endinterface

// file: logic/aps_deglitch.sv
// deglitch filter for the host-supply power-good level
// assumes an input synchronous to clk_i
`timescale 1ns/100ps
`include "aps_defs.svh"

module aps_deglitch #(
  parameter int unsigned DEGLITCH_CYC = `APS_DEGLITCH_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  aps_pg_if.filt pg
);
  import aps_pkg::*;

  localparam logic [15:0] LAST = 16'(DEGLITCH_CYC - 1);

  logic good_q, good_d;
  logic [15:0] cnt_q, cnt_d;

  // ----------------------------------------
  // filter
  // ----------------------------------------
  // output follows only after the input held its new level for the whole window
  always_comb begin
    good_d = good_q;
    cnt_d = 16'h0000;
    if (pg.raw != good_q) begin
      if (cnt_q == LAST) begin
        good_d = pg.raw; // R12
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      good_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else begin
      good_q <= good_d;
      cnt_q <= cnt_d;
    end
  end

  assign pg.good = good_q;

  AST_DEGLITCH_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    $changed(good_q) |-> ($past(cnt_q) == LAST && $past(pg.raw) == good_q))
    else $error("power-good changed before the deglitch window ran out");

endmodule

// file: sim/aps_far_model.sv
// far side of the sequencer: boost converter and host regulator ramps
// assumes enables and levels come from aps_seq on the same clock
`timescale 1ns/100ps

module aps_far_model
  import aps_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic boost_enable_i,
  input aps_pkg::aps_bst_lvl_t boost_setting_i,
  input wire logic boost_hold_i,
  input wire logic host_enable_i,
  input aps_pkg::aps_host_lvl_t host_setting_i,
  input wire logic host_fail_i,
  output logic boost_good_o,
  output logic host_good_o
);
  logic [2:0] bst_cnt_q;
  logic [2:0] host_cnt_q;
  aps_bst_lvl_t bst_lvl_q;
  aps_host_lvl_t host_lvl_q;

  // a new level restarts the ramp, so power-good falls before it comes back
  always_ff @(posedge clk_i) begin
    bst_lvl_q <= boost_setting_i;
    host_lvl_q <= host_setting_i;
    if (rst_i || !boost_enable_i || bst_lvl_q != boost_setting_i) begin
      bst_cnt_q <= 3'h0;
    end else if (bst_cnt_q != 3'h4) begin
      bst_cnt_q <= bst_cnt_q + 3'h1;
    end
    if (rst_i || !host_enable_i || host_lvl_q != host_setting_i) begin
      host_cnt_q <= 3'h0;
    end else if (host_cnt_q != 3'h6) begin
      host_cnt_q <= host_cnt_q + 3'h1;
    end
  end

  // hold and fail only mask the flag, so a short fail pulse is a glitch
  // a level change drops power-good in the same cycle, so a stale good never passes for the new target
  assign boost_good_o = (bst_cnt_q == 3'h4) && !boost_hold_i && (bst_lvl_q == boost_setting_i);
  assign host_good_o = (host_cnt_q == 3'h6) && !host_fail_i && (host_lvl_q == host_setting_i);
endmodule

// file: sim/alarm_afe_power_sequencer_tb.sv
// self-checking bench of the alarm front-end power sequencer
// assumes aps_seq with short counts and the far-side model aps_far_model
`timescale 1ns/100ps

module alarm_afe_power_sequencer_tb;
  import aps_pkg::*;
  localparam int INIT = 20;
  localparam int STRAP = 10;
  localparam int TMO = 40;
  localparam int DGL = 5;
  logic clk_i, rst_i, core_i, hold_i, fail_i, cyc, stb, we, ack;
  logic [1:0] strap_i;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, rd, v;
  logic bgood, hgood, ben, hen, ien, photo, active, fault;
  aps_bst_lvl_t blvl;
  aps_host_lvl_t hlvl;
  int err_total, total_checks, n;
  int exp_host[4] = '{0, 1, 2, 3};
  int exp_bst[4] = '{0, 0, 1, 2};

  aps_seq #(.INIT_CYC(INIT), .STRAP_CYC(STRAP), .HOST_TIMEOUT_CYC(TMO), .DEGLITCH_CYC(DGL)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .core_supply_up_i(core_i), .boost_good_i(bgood),
    .host_supply_good_i(hgood), .supply_select_strap_i(strap_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .boost_enable_o(ben), .boost_output_setting_o(blvl), .host_regulator_enable_o(hen),
    .host_supply_voltage_setting_o(hlvl), .internal_regulator_enable_o(ien),
    .photo_reference_low_o(photo), .active_o(active), .fault_o(fault));

  aps_far_model u_far (
    .clk_i(clk_i), .rst_i(rst_i), .boost_enable_i(ben), .boost_setting_i(blvl), .boost_hold_i(hold_i),
    .host_enable_i(hen), .host_setting_i(hlvl), .host_fail_i(fail_i), .boost_good_o(bgood),
    .host_good_o(hgood));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // read data and ack are registered, so the pre-edge value is the sampled one
  // no cycle count is assumed here: only the watchdog ends a hung access
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  function automatic bit hit(input int s);
    return (s == 0) ? ben === 1'b1 : (s == 1) ? active === 1'b1 : (s == 2) ? fault === 1'b1 : hen === 1'b1;
  endfunction

  task automatic wait_on(input int s, input int lim, output int cnt);
    cnt = 0;
    while (cnt < lim && !hit(s)) begin
      @(posedge clk_i);
      cnt++;
    end
    if (cnt >= lim) begin
      err_total++;
      $display("wrong value at %0t: wait ran out", $time);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // the whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    $display("wrong value at %0t: watchdog ran out", $time);
    print_verdict();
  end

  initial begin
    void'($urandom(28312));
    rst_i = 1'b1;
    core_i = 1'b0;
    hold_i = 1'b0;
    fail_i = 1'b0;
    strap_i = 2'h0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(ien, 1);
    chk(blvl, APS_BST_3V8);
    wb(1'b0, 8'h08, $urandom);
    chk(rd, 0);
    for (int c = 0; c < 5; c++) begin
      strap_i <= c[1:0];
      hold_i <= 1'b1;
      @(posedge clk_i);
      core_i <= 1'b1;
      wait_on(0, INIT + 6, n);
      chk(n >= INIT && n <= INIT + 3, 1);
      chk(blvl, APS_BST_3V8);
      repeat (30) @(posedge clk_i);
      chk({ben, hen}, 2'h2);
      hold_i <= 1'b0;
      wait_on(3, STRAP + 20, n);
      chk(n >= STRAP, 1);
      chk(hlvl, exp_host[c % 4]);
      chk(blvl, exp_bst[c % 4]);
      chk(active, 0);
      wait_on(1, 30, n);
      chk(n >= DGL, 1);
      wb(1'b0, 8'h04, 32'h0);
      chk(rd[9:8], c % 4);
      if (c < 4) begin
        core_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk({active, ben, hen, blvl}, {3'h0, APS_BST_3V8});
      end
    end
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      v = {25'h0, i[2:0], 2'h0, v[1:0]};
      wb(1'b1, 8'h00, v);
      @(posedge clk_i);
      chk(hlvl, v[1:0]);
      chk(photo, v[4] && (v[5] || v[6]));
      wb(1'b0, 8'h00, 32'h0);
      chk(rd, v);
    end
    // a write without the low byte lane must leave the controls alone
    sel <= 4'hE;
    wb(1'b1, 8'h00, 32'h7F);
    sel <= 4'hF;
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, v);
    wb(1'b1, 8'h00, 32'h4);
    @(posedge clk_i);
    chk(hen, 0);
    wb(1'b1, 8'h00, 32'h0);
    repeat (30) @(posedge clk_i);
    fail_i <= 1'b1;
    repeat (DGL - 2) @(posedge clk_i);
    fail_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0);
    chk({rd[2:1], rd[3]}, 3'h6);
    fail_i <= 1'b1;
    repeat (DGL + 4) @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd[1], 0);
    // a level change restarts the supervision timer
    wb(1'b1, 8'h00, 32'h1);
    wait_on(2, TMO + DGL + 20, n);
    chk(n >= TMO - 3, 1);
    wb(1'b0, 8'h04, 32'h0);
    chk({rd[3], rd[0]}, 2'h3);
    wb(1'b1, 8'h00, 32'h9);
    wait_on(3, 10, n);
    repeat (TMO + 10) @(posedge clk_i);
    chk(fault, 0);
    fail_i <= 1'b0;
    wb(1'b1, 8'h04, 32'h1);
    wait_on(1, 40, n);
    chk(active, 1);
    print_verdict();
  end
endmodule
